// ===== core/pviu_core.v
/*
 * Prioritized vector interrupt unit: collects twelve sources, gates them,
 * merges shared pairs, resolves priority and runs the vector fetch and
 * context push for the processor core. Registers over classic Wishbone.
 * Assumes same-clock peripheral event pulses, asynchronous pin inputs,
 * a core that holds PC_IN and PS_IN while CORE_HALT is high, and a vector
 * memory that returns data the cycle after FETCH_STROBE/FETCH_ADDR.
 */
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "pviu_defines.vh"

// What this block does
// - Handle twelve sources: four pins, seven peripherals, one software break.
// - Accept a source only when enabled, requested and global disable clear.
// - Software writes can clear request bits but never set them.
// - Enable bits are freely written by software.
// - Edge selection bits 7..4 choose the active source of each shared pair.
// - Reset and break are unmaskable; all others blocked by global disable.
// - Simultaneous requests are serviced in fixed priority order.
// - On acceptance halt processing and push PC and status onto the stack, except for reset.
// - On acceptance set global disable and clear the serviced request bit.
// - Fetch the vector into PC while the push is in progress.
// - Changing a pin's active edge may set its request bit.
// - Reset is highest priority, vector at FFFD/FFFC.
// - Serial receive done is priority 2 at FFFB/FFFA, valid when selected.
// - Priority 3 at FFF9/FFF8 shares serial transmit and pin B edge.
// - Pin A selectable edge is priority 4 at FFF7/FFF6.
// - Priority 5 at FFF5/FFF4 shares timer X underflow and key falling.
// - Timer 1 underflow is priority 6 at FFF3/FFF2.
// - Priority 7 at FFF1/FFF0 shares timer 2 and clocked serial done.
// - Priority 8 at FFEF/FFEE shares timer event pin edge and converter.
// - Software break is lowest priority 9 at FFED/FFEC, unmaskable.
// - Vector pair holds jump address, high byte at higher address.
module pviu_core (
    input wire CORE_CLK,
    input wire RESETN,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    output reg WB_ERR_O,
    input wire EXT_IRQ_PIN_A,
    input wire EXT_IRQ_PIN_B,
    input wire TIMER_EVENT_PIN,
    input wire [7:0] PORT0_PINS,
    input wire [7:0] PORT0_DIR,
    input wire UART_SELECTED,
    input wire UART_RX_DONE,
    input wire UART_TX_DONE,
    input wire TIMER_X_UNDERFLOW,
    input wire TIMER_1_UNDERFLOW,
    input wire TIMER_2_UNDERFLOW,
    input wire CSIO_DONE,
    input wire ADC_DONE,
    input wire SOFTWARE_BREAK_INSTRUCTION,
    input wire CORE_BOUNDARY,
    input wire CORE_IFLAG,
    input wire [15:0] PC_IN,
    input wire [7:0] PS_IN,
    input wire [7:0] FETCH_DATA,
    output reg INT_PENDING,
    output reg CORE_HALT,
    output reg PUSH_STROBE,
    output reg [7:0] PUSH_DATA,
    output reg FETCH_STROBE,
    output reg [15:0] FETCH_ADDR,
    output reg [15:0] NEW_PC,
    output reg PC_LOAD,
    output reg SET_IFLAG,
    output reg [3:0] SERVICE_PRIORITY
);

    localparam NSRC = `PVIU_NSRC;
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_PUSH_HI = 5'h02;
    localparam [4:0] S_PUSH_LO = 5'h04;
    localparam [4:0] S_PUSH_PS = 5'h08;
    localparam [4:0] S_LOAD = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Lowest set line index wins; result is the priority number, 0 if none
    function [3:0] pick_priority;
        input [8:0] lines;
        integer i;
        begin
            pick_priority = 4'h0;
            for (i = 8; i >= 0; i = i - 1) begin
                if (lines[i]) begin
                    pick_priority = i[3:0] + 4'h1;
                end
            end
        end
    endfunction

    // Byte-lane merge of a write into the low bytes of a register
    function [15:0] lane_merge;
        input [15:0] old;
        input [15:0] wdata;
        input [1:0] sel;
        begin
            lane_merge = {sel[1] ? wdata[15:8] : old[15:8], sel[0] ? wdata[7:0] : old[7:0]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts when 2nd and 3rd agree

    wire [10:0] pin_raw = {PORT0_PINS | PORT0_DIR, TIMER_EVENT_PIN, EXT_IRQ_PIN_B, EXT_IRQ_PIN_A};
    reg [10:0] sync1;
    reg [10:0] sync2;
    reg [10:0] sync3;
    reg [10:0] pin_stable;
    reg [4:0] warm;

    // Warm-up shifter: pin edges are ignored until the synchroniser holds real levels
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sync1 <= 11'h000;
            sync2 <= 11'h000;
            sync3 <= 11'h000;
            pin_stable <= 11'h000;
            warm <= 5'h00;
        end else begin
            warm <= {warm[3:0], 1'b1};
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            pin_stable <= ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & pin_stable);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and edge detection

    reg [NSRC-1:0] request;
    reg [NSRC-1:0] enable;
    reg [7:0] edge_sel;
    reg break_pend;
    reg reset_pend;
    reg [4:0] state;
    reg [7:0] vec_lo_data;
    reg [3:0] last_priority;
    reg [2:0] active_q;
    reg key_q;

    // Polarity bit flips the pin so a rising active level is the event;
    // flipping the polarity itself can therefore raise an event
    wire [2:0] active_lvl = pin_stable[2:0] ^ {edge_sel[`PVIU_EDGE_TEV],
        edge_sel[`PVIU_EDGE_PIN_B], edge_sel[`PVIU_EDGE_PIN_A]};
    // A pin idling high would otherwise look like a fresh edge right after reset
    wire [2:0] pin_event = active_lvl & ~active_q & {3{warm[4]}};
    wire key_lvl = &pin_stable[10:3]; // Output-mode bits forced high
    wire key_event = key_q & ~key_lvl;

    // Shared pair selection: 0 picks the first source, 1 the second
    wire sel_pinb = edge_sel[`PVIU_SEL_TX_PINB];
    wire sel_key = edge_sel[`PVIU_SEL_TMX_KEY];
    wire sel_csio = edge_sel[`PVIU_SEL_TM2_CSIO];
    wire sel_adc = edge_sel[`PVIU_SEL_TEV_ADC];

    // Raw events; the unselected source of a pair never raises a request
    wire [NSRC-1:0] src_event;
    assign src_event[`PVIU_SRC_UART_RX] = UART_RX_DONE & UART_SELECTED;
    assign src_event[`PVIU_SRC_UART_TX] = UART_TX_DONE & UART_SELECTED & ~sel_pinb;
    assign src_event[`PVIU_SRC_PIN_B] = pin_event[1] & sel_pinb;
    assign src_event[`PVIU_SRC_PIN_A] = pin_event[0];
    assign src_event[`PVIU_SRC_TIMER_X] = TIMER_X_UNDERFLOW & ~sel_key;
    assign src_event[`PVIU_SRC_KEY] = key_event & sel_key;
    assign src_event[`PVIU_SRC_TIMER_1] = TIMER_1_UNDERFLOW;
    assign src_event[`PVIU_SRC_TIMER_2] = TIMER_2_UNDERFLOW & ~sel_csio;
    assign src_event[`PVIU_SRC_CSIO] = CSIO_DONE & sel_csio;
    assign src_event[`PVIU_SRC_TEV] = pin_event[2] & ~sel_adc;
    assign src_event[`PVIU_SRC_ADC] = ADC_DONE & sel_adc;

    // Maskable sources need request, enable and a clear global flag
    wire [NSRC-1:0] armed = request & enable & {NSRC{~CORE_IFLAG}};

    // Priority lines, index 0 is priority 1
    wire [8:0] lines;
    assign lines[0] = reset_pend;
    assign lines[1] = armed[`PVIU_SRC_UART_RX] & UART_SELECTED;
    assign lines[2] = sel_pinb ? armed[`PVIU_SRC_PIN_B] : armed[`PVIU_SRC_UART_TX];
    assign lines[3] = armed[`PVIU_SRC_PIN_A];
    assign lines[4] = sel_key ? armed[`PVIU_SRC_KEY] : armed[`PVIU_SRC_TIMER_X];
    assign lines[5] = armed[`PVIU_SRC_TIMER_1];
    assign lines[6] = sel_csio ? armed[`PVIU_SRC_CSIO] : armed[`PVIU_SRC_TIMER_2];
    assign lines[7] = sel_adc ? armed[`PVIU_SRC_ADC] : armed[`PVIU_SRC_TEV];
    assign lines[8] = break_pend;

    wire [3:0] win_prio = pick_priority(lines);

    // Vector low address and the request bit serviced by the winner
    reg [15:0] win_vec;
    reg [NSRC-1:0] win_clr;
    always @* begin
        win_clr = {NSRC{1'b0}};
        case (win_prio)
            4'h1: begin
                win_vec = `PVIU_VEC_P1;
            end
            4'h2: begin
                win_vec = `PVIU_VEC_P2;
                win_clr[`PVIU_SRC_UART_RX] = 1'b1;
            end
            4'h3: begin
                win_vec = `PVIU_VEC_P3;
                win_clr[`PVIU_SRC_PIN_B] = sel_pinb;
                win_clr[`PVIU_SRC_UART_TX] = ~sel_pinb;
            end
            4'h4: begin
                win_vec = `PVIU_VEC_P4;
                win_clr[`PVIU_SRC_PIN_A] = 1'b1;
            end
            4'h5: begin
                win_vec = `PVIU_VEC_P5;
                win_clr[`PVIU_SRC_KEY] = sel_key;
                win_clr[`PVIU_SRC_TIMER_X] = ~sel_key;
            end
            4'h6: begin
                win_vec = `PVIU_VEC_P6;
                win_clr[`PVIU_SRC_TIMER_1] = 1'b1;
            end
            4'h7: begin
                win_vec = `PVIU_VEC_P7;
                win_clr[`PVIU_SRC_CSIO] = sel_csio;
                win_clr[`PVIU_SRC_TIMER_2] = ~sel_csio;
            end
            4'h8: begin
                win_vec = `PVIU_VEC_P8;
                win_clr[`PVIU_SRC_ADC] = sel_adc;
                win_clr[`PVIU_SRC_TEV] = ~sel_adc;
            end
            default: begin
                win_vec = `PVIU_VEC_P9;
            end
        endcase
    end

    // Reset is taken at once; others wait for an instruction boundary
    wire accept = state[0] & (reset_pend | (CORE_BOUNDARY & (win_prio != 4'h0)));

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after the strobe, write on the ack edge

    wire bus_req = WB_CYC_I & WB_STB_I;
    wire bus_done = bus_req & (WB_ACK_O | WB_ERR_O);
    wire hit_req = WB_ADR_I == `PVIU_OFS_REQUEST;
    wire hit_ena = WB_ADR_I == `PVIU_OFS_ENABLE;
    wire hit_edge = WB_ADR_I == `PVIU_OFS_EDGE_SEL;
    wire hit_stat = WB_ADR_I == `PVIU_OFS_STATUS;
    wire hit_any = hit_req | hit_ena | hit_edge | hit_stat;
    wire wr_done = bus_done & WB_ACK_O & WB_WE_I;

    // Software mask: written zeros clear, written ones keep
    wire [15:0] req_keep = lane_merge(16'hffff, WB_DAT_I[15:0], WB_SEL_I[1:0]);
    wire [15:0] ena_new = lane_merge({5'h00, enable}, WB_DAT_I[15:0], WB_SEL_I[1:0]);
    wire [15:0] edge_new = lane_merge({8'h00, edge_sel}, WB_DAT_I[15:0], WB_SEL_I[1:0]);
    wire [NSRC-1:0] sw_keep = (wr_done & hit_req) ? req_keep[NSRC-1:0] : {NSRC{1'b1}};
    wire [NSRC-1:0] hw_clr = accept ? win_clr : {NSRC{1'b0}};

    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        if (hit_req) begin
            rd_mux[NSRC-1:0] = request;
        end else if (hit_ena) begin
            rd_mux[NSRC-1:0] = enable;
        end else if (hit_edge) begin
            rd_mux[7:0] = edge_sel;
        end else if (hit_stat) begin
            rd_mux[3:0] = win_prio;
            rd_mux[`PVIU_STAT_BREAK] = break_pend;
            rd_mux[`PVIU_STAT_BUSY] = ~state[0];
            rd_mux[11:8] = last_priority;
        end
    end

    // Bus handshake and register file; a hardware set beats any clear
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            WB_ACK_O <= 1'b0;
            WB_ERR_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
            request <= `PVIU_RST_REQUEST;
            enable <= `PVIU_RST_ENABLE;
            edge_sel <= `PVIU_RST_EDGE_SEL;
            active_q <= 3'h0;
            key_q <= 1'b0;
            break_pend <= 1'b0;
            INT_PENDING <= 1'b0;
        end else begin
            WB_ACK_O <= bus_req & hit_any & ~WB_ACK_O & ~WB_ERR_O;
            WB_ERR_O <= bus_req & ~hit_any & ~WB_ACK_O & ~WB_ERR_O;
            WB_DAT_O <= (bus_req & ~WB_ACK_O) ? rd_mux : 32'h00000000;
            active_q <= active_lvl;
            key_q <= key_lvl;
            request <= (request & sw_keep & ~hw_clr) | src_event;
            if (wr_done & hit_ena) begin
                enable <= ena_new[NSRC-1:0];
            end
            if (wr_done & hit_edge) begin
                edge_sel <= edge_new[7:0];
            end
            break_pend <= SOFTWARE_BREAK_INSTRUCTION
                | (break_pend & ~(accept & (win_prio == 4'h9)));
            INT_PENDING <= win_prio != 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Acceptance sequence: push PCH, PCL, PS while fetching vector bytes

    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state <= S_IDLE;
            reset_pend <= 1'b1;
            vec_lo_data <= 8'h00;
            last_priority <= 4'h0;
            CORE_HALT <= 1'b0;
            PUSH_STROBE <= 1'b0;
            PUSH_DATA <= 8'h00;
            FETCH_STROBE <= 1'b0;
            FETCH_ADDR <= 16'h0000;
            NEW_PC <= 16'h0000;
            PC_LOAD <= 1'b0;
            SET_IFLAG <= 1'b0;
            SERVICE_PRIORITY <= 4'h0;
        end else begin
            case (state)
                S_IDLE: begin
                    PC_LOAD <= 1'b0;
                    if (accept) begin
                        state <= S_PUSH_HI;
                        reset_pend <= 1'b0;
                        last_priority <= win_prio;
                        SERVICE_PRIORITY <= win_prio;
                        CORE_HALT <= 1'b1;
                        SET_IFLAG <= 1'b1;
                        PUSH_STROBE <= ~reset_pend; // Reset pushes nothing
                        PUSH_DATA <= PC_IN[15:8];
                        FETCH_STROBE <= 1'b1;
                        FETCH_ADDR <= win_vec;
                    end
                end
                S_PUSH_HI: begin
                    state <= S_PUSH_LO;
                    SET_IFLAG <= 1'b0;
                    PUSH_DATA <= PC_IN[7:0];
                    FETCH_ADDR <= FETCH_ADDR | 16'h0001;
                end
                S_PUSH_LO: begin
                    state <= S_PUSH_PS;
                    vec_lo_data <= FETCH_DATA;
                    PUSH_DATA <= PS_IN;
                    FETCH_STROBE <= 1'b0;
                end
                S_PUSH_PS: begin
                    state <= S_LOAD;
                    PUSH_STROBE <= 1'b0;
                    NEW_PC <= {FETCH_DATA, vec_lo_data};
                    PC_LOAD <= 1'b1;
                end
                S_LOAD: begin
                    state <= S_IDLE;
                    PC_LOAD <= 1'b0;
                    CORE_HALT <= 1'b0;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// ===== core/pviu_defines.vh
/*
 * Constants of the prioritized vector interrupt unit: register offsets,
 * field positions, reset values, source indices and vector addresses.
 * Assumes it is included by bare name from the design file only.
 */
`ifndef PVIU_DEFINES_VH
`define PVIU_DEFINES_VH

// Wishbone register byte offsets
`define PVIU_OFS_REQUEST 8'h00
`define PVIU_OFS_ENABLE 8'h04
`define PVIU_OFS_EDGE_SEL 8'h08
`define PVIU_OFS_STATUS 8'h0c

// Reset values
`define PVIU_RST_REQUEST 11'h000
`define PVIU_RST_ENABLE 11'h000
`define PVIU_RST_EDGE_SEL 8'h00

// Source bit positions in request and enable registers
`define PVIU_NSRC 11
`define PVIU_SRC_UART_RX 0
`define PVIU_SRC_UART_TX 1
`define PVIU_SRC_PIN_B 2
`define PVIU_SRC_PIN_A 3
`define PVIU_SRC_TIMER_X 4
`define PVIU_SRC_KEY 5
`define PVIU_SRC_TIMER_1 6
`define PVIU_SRC_TIMER_2 7
`define PVIU_SRC_CSIO 8
`define PVIU_SRC_TEV 9
`define PVIU_SRC_ADC 10

// Edge selection register fields
`define PVIU_EDGE_PIN_A 0
`define PVIU_EDGE_PIN_B 1
`define PVIU_EDGE_TEV 2
`define PVIU_SEL_TX_PINB 4
`define PVIU_SEL_TMX_KEY 5
`define PVIU_SEL_TM2_CSIO 6
`define PVIU_SEL_TEV_ADC 7

// Status register fields
`define PVIU_STAT_BREAK 4
`define PVIU_STAT_BUSY 5

// Low-byte vector address per priority; the high byte sits one above
`define PVIU_VEC_P1 16'hfffc
`define PVIU_VEC_P2 16'hfffa
`define PVIU_VEC_P3 16'hfff8
`define PVIU_VEC_P4 16'hfff6
`define PVIU_VEC_P5 16'hfff4
`define PVIU_VEC_P6 16'hfff2
`define PVIU_VEC_P7 16'hfff0
`define PVIU_VEC_P8 16'hffee
`define PVIU_VEC_P9 16'hffec

`endif

// ===== tb/prioritized_vector_interrupt_unit_test.sv
/* Self-checking bench for the interrupt unit with a core partner model.
   Assumes the checker is bound by its own file. */
`timescale 1ns/10ps
module prioritized_vector_interrupt_unit_test;
logic clk = 0, rstn = 0, cyc = 0, we = 0, iflag = 1, usel = 1, er;
logic [7:0] adr = 8'h00;
logic [31:0] dat = 32'h0, rd, en;
logic [11:0] src = 12'h000;
wire ack, err, halt, fstb, pcload, bnd, pend;
wire [31:0] dato;
wire [15:0] faddr, newpc, pcin;
wire [7:0] fdata;
wire [3:0] prio;
int mismatches = 0, samples_checked = 0, loads = 0, s, n;
logic [3:0] pr [0:10] = '{2, 3, 3, 4, 5, 5, 6, 7, 7, 8, 8};
logic [7:0] mk [0:10] = '{0, 16, 16, 0, 32, 32, 0, 64, 64, 128, 128};
always #50 clk = ~clk;
// Event lines come from src; key pin 0 falls when src[5] rises
pviu_core DUT (
    .CORE_CLK(clk), .RESETN(rstn), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dato), .WB_ACK_O(ack),
    .WB_ERR_O(err), .EXT_IRQ_PIN_A(src[3]), .EXT_IRQ_PIN_B(src[2]), .TIMER_EVENT_PIN(src[9]),
    .PORT0_PINS({7'h7f, ~src[5]}), .PORT0_DIR(8'h00), .UART_SELECTED(usel),
    .UART_RX_DONE(src[0]), .UART_TX_DONE(src[1]), .TIMER_X_UNDERFLOW(src[4]),
    .TIMER_1_UNDERFLOW(src[6]), .TIMER_2_UNDERFLOW(src[7]), .CSIO_DONE(src[8]),
    .ADC_DONE(src[10]), .SOFTWARE_BREAK_INSTRUCTION(src[11]), .CORE_BOUNDARY(bnd),
    .CORE_IFLAG(iflag), .PC_IN(pcin), .PS_IN(pcin[7:0] ^ 8'ha5), .FETCH_DATA(fdata),
    .INT_PENDING(pend), .CORE_HALT(halt), .PUSH_STROBE(), .PUSH_DATA(), .FETCH_STROBE(fstb),
    .FETCH_ADDR(faddr), .NEW_PC(newpc), .PC_LOAD(pcload), .SET_IFLAG(),
    .SERVICE_PRIORITY(prio));
pviu_core_model u_core (.clk(clk), .rst_n(rstn), .fetch_strobe(fstb), .fetch_addr(faddr),
    .core_halt(halt), .pc_load(pcload), .new_pc(newpc), .fetch_data(fdata), .pc_in(pcin),
    .core_boundary(bnd));
////////////////////////////////////////////////////////////////////////////////
task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
        mismatches++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask
function logic [15:0] exp_pc(input logic [3:0] p);
    logic [7:0] lo;
    lo = 8'hfe - {3'h0, p, 1'b0};
    exp_pc = {(lo | 8'h01) ^ 8'h3c, lo ^ 8'h3c};
endfunction
function logic [7:0] sel(input int t);
    sel = (t == 2 || t == 5 || t == 8 || t == 10) ? mk[t] : 8'h00;
endfunction
// Classic cycle held until ack or err is sampled at a rising edge, released at that edge
task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
        @(posedge clk);
    end while (ack !== 1'b1 && err !== 1'b1);
    rd = dato;
    er = err;
    cyc <= 1'b0;
endtask
// Lines idle, then one event; pins (key pin low) keep their level, pulses are cleared
task fire(input int t);
    @(posedge clk);
    src <= 12'h000;
    repeat (4) @(posedge clk);
    src[t] <= 1'b1;
    @(posedge clk);
    src <= src & 12'h22c;
    repeat (4) @(posedge clk);
endtask
task wait_load(input int lim);
    int k;
    n = loads;
    for (k = 0; k < lim && loads == n; k++) @(posedge clk);
endtask
task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
// Every vector load is compared with the memory image
always @(negedge clk) begin
    if (pcload === 1'b1) begin
        check(newpc, exp_pc(prio));
        loads++;
    end
end
initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run;
end
////////////////////////////////////////////////////////////////////////////////
initial begin
    void'($urandom(32'hb8f4d918));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    wait_load(20);
    check(prio, 4'h1);
    for (s = 0; s < 3; s++) begin
        wb(1'b0, 8'(s * 4), 32'h0);
        check(rd, 32'h0);
    end
    wb(1'b0, 8'h10, 32'h0);
    check(er, 1'b1);
    wb(1'b1, 8'h00, 32'h7ff);
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    en = $urandom & 32'h7ff;
    wb(1'b1, 8'h04, en);
    wb(1'b0, 8'h04, 32'h0);
    check(rd, en);
    // Flipping pin A's edge while it sits low raises its request
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h08, 32'h1);
    repeat (4) @(posedge clk);
    wb(1'b0, 8'h00, 32'h0);
    check(rd[3], 1'b1);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b1, 8'h00, 32'h0);
    // Each request source: wrong pair select if shared, then masked request, then random enable
    for (s = 0; s <= 10; s++) begin
        if (mk[s] != 8'h00) begin
            wb(1'b1, 8'h08, {24'h0, sel(s) ^ mk[s]});
            fire(s);
            wb(1'b0, 8'h00, 32'h0);
            check(rd[s], 1'b0);
        end
        wb(1'b1, 8'h08, {24'h0, sel(s)});
        fire(s);
        wb(1'b0, 8'h00, 32'h0);
        check(rd[s], 1'b1);
        en = $urandom % 2;
        wb(1'b1, 8'h04, en << s);
        iflag <= 1'b0;
        wait_load(30);
        check(loads - n, en);
        if (en[0])
            check(prio, pr[s]);
        iflag <= 1'b1;
        wb(1'b0, 8'h00, 32'h0);
        check(rd[s], !en[0]);
        wb(1'b1, 8'h00, 32'h0);
    end
    // Serial events are dropped while the serial function is not selected
    usel <= 1'b0;
    fire(0);
    fire(1);
    wb(1'b0, 8'h00, 32'h0);
    check(rd[1:0], 2'h0);
    usel <= 1'b1;
    // Three sources at once are served in priority order
    wb(1'b1, 8'h04, 32'h7ff);
    @(posedge clk);
    src <= 12'h0c1;
    @(posedge clk);
    src <= 12'h000;
    iflag <= 1'b0;
    for (s = 0; s < 3; s++) begin
        wait_load(30);
        check(prio, s == 0 ? 4'h2 : 4'(5 + s));
        check(pend, s < 2);
    end
    iflag <= 1'b1;
    fire(11);
    wait_load(30);
    check(prio, 4'h9);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    wait_load(20);
    check(prio, 4'h1);
    complete_run;
end
endmodule

// ===== tb/pviu_core_model.sv
/* Core-side partner: vector memory and a running program counter.
   Assumes the unit presents its fetch address in the strobe cycle. */
`timescale 1ns/10ps
module pviu_core_model (
    input wire clk,
    input wire rst_n,
    input wire fetch_strobe,
    input wire [15:0] fetch_addr,
    input wire core_halt,
    input wire pc_load,
    input wire [15:0] new_pc,
    output reg [7:0] fetch_data,
    output reg [15:0] pc_in,
    output reg core_boundary
);
// Memory answers a cycle late; otherwise it toggles so stale data never passes
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        fetch_data <= 8'h00;
        pc_in <= 16'h1234;
        core_boundary <= 1'b0;
    end else begin
        fetch_data <= fetch_strobe ? (fetch_addr[7:0] ^ 8'h3c) : ~fetch_data;
        // PC moves only mid-instruction, so the push sees a steady context
        if (pc_load)
            pc_in <= new_pc;
        else if (!core_halt && !core_boundary)
            pc_in <= pc_in + 16'h0103;
        if (!core_halt)
            core_boundary <= ~core_boundary;
    end
end
endmodule

// ===== tb/pviu_core_props.sv
/* Port checker for the interrupt unit: bus answers, service sequence, vectors.
   Assumes one clock and async low reset; bound to every pviu_core. */
`timescale 1ns/10ps
module pviu_core_props (
    input wire CORE_CLK,
    input wire RESETN,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire [7:0] WB_ADR_I,
    input wire [31:0] WB_DAT_O,
    input wire WB_ACK_O,
    input wire WB_ERR_O,
    input wire CORE_IFLAG,
    input wire [15:0] PC_IN,
    input wire [7:0] PS_IN,
    input wire [7:0] FETCH_DATA,
    input wire CORE_HALT,
    input wire PUSH_STROBE,
    input wire [7:0] PUSH_DATA,
    input wire FETCH_STROBE,
    input wire [15:0] FETCH_ADDR,
    input wire PC_LOAD,
    input wire [15:0] NEW_PC,
    input wire SET_IFLAG,
    input wire [3:0] SERVICE_PRIORITY
);
default clocking @(posedge CORE_CLK); endclocking
default disable iff (!RESETN);
// A fresh request and whether its address is one of the four registers
wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
wire mapped = WB_ADR_I[7:4] == 4'h0 && WB_ADR_I[1:0] == 2'h0;
// Steps of one service
sequence s_fetch;
    SET_IFLAG && FETCH_STROBE ##1 FETCH_STROBE && !SET_IFLAG;
endsequence
sequence s_load;
    !FETCH_STROBE ##1 PC_LOAD ##1 !CORE_HALT;
endsequence
sequence s_push;
    PUSH_DATA == PC_IN[15:8] ##1 PUSH_STROBE && PUSH_DATA == PC_IN[7:0]
    ##1 PUSH_STROBE && PUSH_DATA == PS_IN ##1 !PUSH_STROBE;
endsequence
a_bus_ack: assert property (req && mapped |=> WB_ACK_O && !WB_ERR_O)
    else $error("mapped access not acknowledged");
a_bus_err: assert property (req && !mapped |=> WB_ERR_O && !WB_ACK_O)
    else $error("unmapped access not refused");
a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
a_seq_shape: assert property ($rose(CORE_HALT) |-> s_fetch ##1 s_load)
    else $error("service sequence malformed");
a_push_ctx: assert property ($rose(PUSH_STROBE) |-> s_push)
    else $error("context push wrong");
a_reset_nopush: assert property ($rose(CORE_HALT) && SERVICE_PRIORITY == 4'h1
    |-> !PUSH_STROBE [*4])
    else $error("reset service pushed context");
a_vec_addr: assert property ($rose(FETCH_STROBE)
    |-> FETCH_ADDR == 16'hfffe - {11'h0, SERVICE_PRIORITY, 1'b0}
    ##1 FETCH_ADDR == ($past(FETCH_ADDR) | 16'h1))
    else $error("vector address wrong");
a_pc_vector: assert property (PC_LOAD
    |-> NEW_PC == {$past(FETCH_DATA), $past(FETCH_DATA, 2)})
    else $error("new pc not the fetched pair");
a_mask_flag: assert property ($rose(CORE_HALT) && $past(CORE_IFLAG)
    |-> SERVICE_PRIORITY == 4'h1 || SERVICE_PRIORITY == 4'h9)
    else $error("maskable source taken while disabled");
endmodule
bind pviu_core pviu_core_props u_props (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .CORE_IFLAG(CORE_IFLAG), .PC_IN(PC_IN),
    .PS_IN(PS_IN), .FETCH_DATA(FETCH_DATA), .CORE_HALT(CORE_HALT), .PUSH_STROBE(PUSH_STROBE),
    .PUSH_DATA(PUSH_DATA), .FETCH_STROBE(FETCH_STROBE), .FETCH_ADDR(FETCH_ADDR),
    .PC_LOAD(PC_LOAD), .NEW_PC(NEW_PC), .SET_IFLAG(SET_IFLAG),
    .SERVICE_PRIORITY(SERVICE_PRIORITY));
